// file: hdl/bus_monitor_pkg.sv
// Register map, field layout, timing counts and carriers of the bus monitor core
package bus_monitor_pkg;
    localparam int REG_IDX_W = 5;
    localparam logic [4:0] IDX_CONTROL = 5'h00;
    localparam logic [4:0] IDX_STATUS = 5'h01;
    localparam logic [4:0] IDX_CUR_BLOCK = 5'h02;
    localparam logic [4:0] IDX_CUR_CMD = 5'h05;
    localparam logic [4:0] IDX_HP_ENABLE = 5'h07;
    localparam logic [4:0] IDX_HP_STATUS = 5'h08;
    localparam logic [4:0] IDX_STD_ENABLE = 5'h09;
    localparam logic [4:0] IDX_TERM_ADDR = 5'h0A;
    localparam logic [4:0] IDX_SELF_TEST = 5'h0B;
    localparam logic [4:0] IDX_SOFT_RESET = 5'h0C;
    localparam logic [4:0] IDX_MON_CTRL = 5'h0E;
    localparam logic [4:0] IDX_FILTER_LOW = 5'h10;
    localparam logic [4:0] IDX_FILTER_HIGH = 5'h11;
    localparam logic [4:0] IDX_SELF_TEST_RESULT = 5'h12;
    localparam int AXI_ADDR_W = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MODE_SEL_BIT = 10;
    localparam logic [15:0] CTRL_RW_MASK = 16'h1980;
    localparam logic [15:0] HP_EN_MASK = 16'h013B;
    localparam logic [15:0] STD_EN_MASK = 16'h0003;
    localparam logic [15:0] MON_CTRL_MASK = 16'hE000;
    localparam int HP_OVERRUN = 8;
    localparam int HP_SUBSYS = 5;
    localparam int HP_END_TEST = 4;
    localparam int HP_TEST_FAIL = 3;
    localparam int HP_MSG_ERR = 1;
    localparam int HP_STD = 0;
    localparam int STD_MSG_ERR = 1;
    localparam int STD_BLOCK = 0;
    localparam int MON_SELECT = 15;
    localparam int MON_ALL = 14;
    localparam int MON_SELECTED = 13;
    localparam int TA_MODE_SEL = 8;
    localparam int TA_LOCK = 7;
    localparam logic [15:0] BLK_CMD1 = 16'h0001;
    localparam logic [15:0] BLK_DPTR = 16'h0003;
    localparam logic [15:0] BLK_STAT1 = 16'h0004;
    localparam logic [15:0] BLK_TAIL = 16'h0006;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_US = 64;
    localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int SELF_TEST_US = 100;
    localparam int SELF_TEST_CYCLES = SELF_TEST_US * 1000 / CLK_PERIOD_NS;
    localparam int SOFT_RESET_US = 1;
    localparam int SOFT_RESET_CYCLES = SOFT_RESET_US * 1000 / CLK_PERIOD_NS;
    localparam int PULSE_NS = 320;
    localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] KIND_CMD = 2'h0;
    localparam logic [1:0] KIND_STATUS = 2'h1;
    localparam logic [1:0] KIND_DATA = 2'h2;
    localparam logic [1:0] KIND_END = 2'h3;
    typedef struct packed {
        logic [1:0] kind;
        logic first;
        logic bus_a;
        logic error;
        logic [15:0] value;
    } bus_word_s;
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_s;
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_DPTR = 6'b000010,
        S_WORD = 6'b000100,
        S_HOLD = 6'b001000,
        S_CS = 6'b010000,
        S_TAIL = 6'b100000
    } cap_state_e;
endpackage

// file: hdl/bus_monitor_capture_irq.sv
// Monitor capture engine, interrupt registers and AXI4-Lite register slave
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
module bus_monitor_capture_irq (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [bus_monitor_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [bus_monitor_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire bus_monitor_pkg::bus_word_s word_in,
    input wire logic word_valid,
    output logic word_ready,
    output bus_monitor_pkg::mem_req_s mem_req,
    output logic mem_req_valid,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    input wire logic data_overrun,
    input wire logic mode_lock_pin,
    input wire logic subsystem_fail_pin,
    input wire logic self_test_fault_pin,
    output logic std_irq_level_out,
    output logic std_irq_pulse_out,
    output logic high_prio_irq_out
);
    import bus_monitor_pkg::*;

    // Pin synchronisers
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic subsys_prev_reg;
    wire lock_sync = pin_sync_reg[0];
    wire subsys_sync = pin_sync_reg[1];
    wire fault_sync = pin_sync_reg[2];

    // Registers
    logic [15:0] control_reg;
    logic start_en_reg;
    logic ctrl_written_reg;
    logic [15:0] hp_enable_reg;
    logic [15:0] hp_status_reg;
    logic [15:0] std_enable_reg;
    logic [15:0] mon_ctrl_reg;
    logic [15:0] filter_low_reg;
    logic [15:0] filter_high_reg;
    logic [15:0] cur_block_reg;
    logic [15:0] cur_cmd_reg;
    logic [15:0] test_result_reg;
    logic [11:0] test_cnt_reg;
    logic [5:0] prst_cnt_reg;
    logic [3:0] pulse_cnt_reg;
    logic [11:0] tick_cnt_reg;
    logic [7:0] tag_cnt_reg;
    logic [7:0] tag_last_reg;
    logic [7:0] tag_reg;

    // Capture engine state
    cap_state_e state_reg;
    bus_word_s hold_reg;
    logic skip_reg;
    logic msg_err_reg;
    logic bus_a_reg;
    logic [15:0] dptr_reg;
    logic [5:0] data_cnt_reg;
    logic cmd_cnt_reg;
    logic stat_cnt_reg;

    // AXI slave state
    logic aw_full_reg;
    logic w_full_reg;
    logic [REG_IDX_W-1:0] aw_idx_reg;
    logic [15:0] w_data_reg;
    logic [1:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    wire prst_active = prst_cnt_reg != 6'h00;
    wire test_active = test_cnt_reg != 12'h000;
    wire monitor_mode = mon_ctrl_reg[MON_SELECT] & ~control_reg[CTRL_MODE_SEL_BIT];
    wire monitor_active = monitor_mode & start_en_reg & ~prst_active;

    // Register write decode
    wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg & ce;
    wire [15:0] wmask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire [15:0] wbits = w_data_reg & wmask;
    wire wr_control = do_write & (aw_idx_reg == IDX_CONTROL);
    wire ctrl_open = ~(lock_sync & ctrl_written_reg);
    wire wr_control_ok = wr_control & ctrl_open;
    wire wr_cur_block = do_write & (aw_idx_reg == IDX_CUR_BLOCK);
    wire wr_hp_enable = do_write & (aw_idx_reg == IDX_HP_ENABLE);
    wire wr_hp_status = do_write & (aw_idx_reg == IDX_HP_STATUS);
    wire wr_std_enable = do_write & (aw_idx_reg == IDX_STD_ENABLE);
    wire wr_mon_ctrl = do_write & (aw_idx_reg == IDX_MON_CTRL);
    wire wr_filter_low = do_write & (aw_idx_reg == IDX_FILTER_LOW);
    wire wr_filter_high = do_write & (aw_idx_reg == IDX_FILTER_HIGH);
    wire start_test = do_write & (aw_idx_reg == IDX_SELF_TEST) & (wbits != 16'h0000);
    wire start_prst = do_write & (aw_idx_reg == IDX_SOFT_RESET) & (wbits != 16'h0000);
    wire wr_ro = (aw_idx_reg == IDX_STATUS) | (aw_idx_reg == IDX_CUR_CMD) |
        (aw_idx_reg == IDX_TERM_ADDR) | (aw_idx_reg == IDX_SELF_TEST_RESULT);
    wire wr_mapped = wr_ro | (aw_idx_reg == IDX_CONTROL) | (aw_idx_reg == IDX_CUR_BLOCK) |
        (aw_idx_reg == IDX_HP_ENABLE) | (aw_idx_reg == IDX_HP_STATUS) |
        (aw_idx_reg == IDX_STD_ENABLE) | (aw_idx_reg == IDX_MON_CTRL) |
        (aw_idx_reg == IDX_FILTER_LOW) | (aw_idx_reg == IDX_FILTER_HIGH) |
        (aw_idx_reg == IDX_SELF_TEST) | (aw_idx_reg == IDX_SOFT_RESET);

    // Register read decode
    wire [REG_IDX_W-1:0] ar_idx = s_axi_araddr[REG_IDX_W+1:2];
    wire [15:0] status_word = {monitor_active, test_active, prst_active,
        control_reg[CTRL_MODE_SEL_BIT], bus_a_reg, subsys_sync, 10'h000};
    wire [15:0] term_addr_word = {7'h00, monitor_mode, lock_sync, 7'h00};
    logic [15:0] rd_value;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (ar_idx)
            IDX_CONTROL: rd_value = control_reg & CTRL_RW_MASK;
            IDX_STATUS: rd_value = status_word;
            IDX_CUR_BLOCK: rd_value = cur_block_reg;
            IDX_CUR_CMD: rd_value = cur_cmd_reg;
            IDX_HP_ENABLE: rd_value = hp_enable_reg;
            IDX_HP_STATUS: rd_value = hp_status_reg;
            IDX_STD_ENABLE: rd_value = std_enable_reg;
            IDX_TERM_ADDR: rd_value = term_addr_word;
            IDX_MON_CTRL: rd_value = mon_ctrl_reg;
            IDX_FILTER_LOW: rd_value = filter_low_reg;
            IDX_FILTER_HIGH: rd_value = filter_high_reg;
            IDX_SELF_TEST_RESULT: rd_value = test_result_reg;
            IDX_SELF_TEST, IDX_SOFT_RESET: rd_value = 16'h0000;
            default: begin
                rd_value = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // AXI handshakes
    assign s_axi_awready = ce & ~aw_full_reg & ~bvalid_reg;
    assign s_axi_wready = ce & ~w_full_reg & ~bvalid_reg;
    assign s_axi_arready = ce & ~rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_idx_reg <= '0;
            w_data_reg <= 16'h0000;
            w_strb_reg <= 2'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_idx_reg <= s_axi_awaddr[REG_IDX_W+1:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[15:0];
                w_strb_reg <= s_axi_wstrb[1:0];
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= {16'h0000, rd_value};
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Capture decision from the command word's terminal address
    wire [4:0] cmd_rt = word_in.value[15:11];
    wire [31:0] filter_all = {filter_high_reg, filter_low_reg};
    wire chan_ok = word_in.bus_a ? control_reg[7] : control_reg[8];
    wire rt_wanted = mon_ctrl_reg[MON_ALL] |
        (mon_ctrl_reg[MON_SELECTED] & filter_all[cmd_rt]);
    wire take_word = word_valid & word_ready;
    wire msg_start = take_word & (word_in.kind == KIND_CMD) & word_in.first;
    wire capture = msg_start & monitor_active & chan_ok & rt_wanted;

    // Memory request selection
    wire [15:0] word_addr = (hold_reg.kind == KIND_DATA) ? dptr_reg + {10'h000, data_cnt_reg} :
        (hold_reg.kind == KIND_STATUS) ? cur_block_reg + BLK_STAT1 + {15'h0000, stat_cnt_reg} :
        cur_block_reg + BLK_CMD1 + {15'h0000, cmd_cnt_reg};
    wire std_blk_evt = std_enable_reg[STD_BLOCK];
    wire [15:0] cs_word = {1'b1, msg_err_reg, std_blk_evt, bus_a_reg, 4'h0,
        tag_reg};
    wire [15:0] req_addr = (state_reg == S_DPTR) ? cur_block_reg + BLK_DPTR :
        (state_reg == S_TAIL) ? cur_block_reg + BLK_TAIL :
        (state_reg == S_CS) ? cur_block_reg : word_addr;
    wire req_write = (state_reg == S_WORD) | (state_reg == S_CS);
    assign mem_req_valid = (state_reg == S_DPTR) | (state_reg == S_WORD) |
        (state_reg == S_CS) | (state_reg == S_TAIL);
    assign mem_req = '{write: req_write, addr: req_addr,
        wdata: (state_reg == S_CS) ? cs_word : hold_reg.value};
    assign word_ready = ce & ~prst_active & ((state_reg == S_IDLE) | (state_reg == S_HOLD));
    wire mem_done = ce & mem_req_valid & mem_ack;
    wire block_done = mem_done & (state_reg == S_CS);

    // Interrupt events
    wire err_evt = block_done & msg_err_reg;
    wire std_evt = (block_done & std_blk_evt) |
        (err_evt & std_enable_reg[STD_MSG_ERR]);
    wire test_done = ce & (test_cnt_reg == 12'h001);
    wire test_fail = fault_sync;
    wire [15:0] hp_raw = {7'h00, data_overrun, 2'h0, subsys_sync & ~subsys_prev_reg,
        test_done, test_done & test_fail, 1'b0, err_evt, std_evt};
    wire [15:0] hp_set = hp_raw & hp_enable_reg;
    wire [15:0] hp_clr = wr_hp_status ? wbits : 16'h0000;
    assign std_irq_level_out = hp_status_reg[HP_STD];
    assign std_irq_pulse_out = pulse_cnt_reg != 4'h0;
    assign high_prio_irq_out = |(hp_status_reg & HP_EN_MASK & ~16'h0001);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            subsys_prev_reg <= 1'b0;
            hp_enable_reg <= 16'h0000;
            std_enable_reg <= 16'h0000;
            mon_ctrl_reg <= 16'h0000;
            control_reg <= 16'h0000;
            cur_block_reg <= 16'h0000;
            hp_status_reg <= 16'h0000;
            pulse_cnt_reg <= 4'h0;
            test_cnt_reg <= 12'h000;
            test_result_reg <= 16'h0000;
            prst_cnt_reg <= 6'h00;
            tick_cnt_reg <= 12'h000;
            tag_cnt_reg <= 8'h00;
        end else if (ce) begin
            pin_meta_reg <= {self_test_fault_pin, subsystem_fail_pin, mode_lock_pin};
            pin_sync_reg <= pin_meta_reg;
            subsys_prev_reg <= subsys_sync;
            if (wr_hp_enable) begin
                hp_enable_reg <= ((hp_enable_reg & ~wmask) | wbits) & HP_EN_MASK;
            end
            if (wr_std_enable) begin
                std_enable_reg <= ((std_enable_reg & ~wmask) | wbits) & STD_EN_MASK;
            end
            if (wr_mon_ctrl) begin
                mon_ctrl_reg <= ((mon_ctrl_reg & ~wmask) | wbits) & MON_CTRL_MASK;
            end
            if (wr_control_ok) begin
                control_reg <= ((control_reg & ~wmask) | wbits) & (CTRL_RW_MASK | 16'h0400);
            end
            if (block_done && mem_ack) begin
                cur_block_reg <= cur_block_reg;
            end
            if (state_reg == S_TAIL && mem_done) begin
                cur_block_reg <= mem_rdata;
            end else if (wr_cur_block) begin
                cur_block_reg <= (cur_block_reg & ~wmask) | wbits;
            end
            if (prst_active) begin
                hp_status_reg <= 16'h0000;
            end else begin
                hp_status_reg <= (hp_status_reg & ~hp_clr) | hp_set;
            end
            if (std_evt) begin
                pulse_cnt_reg <= 4'(PULSE_CYCLES);
            end else if (pulse_cnt_reg != 4'h0) begin
                pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
            end
            if (start_test && !test_active) begin
                test_cnt_reg <= 12'(SELF_TEST_CYCLES);
            end else if (test_active) begin
                test_cnt_reg <= test_cnt_reg - 12'h001;
            end
            if (test_done) begin
                test_result_reg <= {15'h0000, test_fail};
            end
            if (start_prst) begin
                prst_cnt_reg <= 6'(SOFT_RESET_CYCLES);
            end else if (prst_active) begin
                prst_cnt_reg <= prst_cnt_reg - 6'h01;
            end
            if (tick_cnt_reg == 12'(TICK_CYCLES - 1)) begin
                tick_cnt_reg <= 12'h000;
                tag_cnt_reg <= tag_cnt_reg + 8'h01;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 12'h001;
            end
        end
    end

    // Registers cleared by programmed reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_en_reg <= 1'b0;
            ctrl_written_reg <= 1'b0;
            filter_low_reg <= 16'h0000;
            filter_high_reg <= 16'h0000;
        end else if (ce) begin
            if (prst_active) begin
                start_en_reg <= 1'b0;
                ctrl_written_reg <= 1'b0;
                filter_low_reg <= 16'h0000;
                filter_high_reg <= 16'h0000;
            end else begin
                if (wr_control_ok) begin
                    start_en_reg <= wbits[CTRL_START_BIT];
                end
                if (wr_control) begin
                    ctrl_written_reg <= 1'b1;
                end
                if (wr_filter_low) begin
                    filter_low_reg <= (filter_low_reg & ~wmask) | wbits;
                end
                if (wr_filter_high) begin
                    filter_high_reg <= (filter_high_reg & ~wmask) | wbits;
                end
            end
        end
    end

    // Capture engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= S_IDLE;
            hold_reg <= '0;
            skip_reg <= 1'b0;
            msg_err_reg <= 1'b0;
            bus_a_reg <= 1'b0;
            dptr_reg <= 16'h0000;
            data_cnt_reg <= 6'h00;
            cmd_cnt_reg <= 1'b0;
            stat_cnt_reg <= 1'b0;
            cur_cmd_reg <= 16'h0000;
            tag_last_reg <= 8'h00;
            tag_reg <= 8'h00;
        end else if (ce) begin
            if (msg_start) begin
                tag_reg <= tag_cnt_reg - tag_last_reg;
                tag_last_reg <= tag_cnt_reg;
                cur_cmd_reg <= word_in.value;
            end
            if (prst_active) begin
                state_reg <= S_IDLE;
                skip_reg <= 1'b0;
            end else begin
                case (state_reg)
                    S_IDLE: begin
                        if (capture) begin
                            hold_reg <= word_in;
                            bus_a_reg <= word_in.bus_a;
                            msg_err_reg <= word_in.error;
                            data_cnt_reg <= 6'h00;
                            cmd_cnt_reg <= 1'b0;
                            stat_cnt_reg <= 1'b0;
                            skip_reg <= 1'b0;
                            state_reg <= S_DPTR;
                        end else if (take_word) begin
                            skip_reg <= msg_start | (skip_reg & (word_in.kind != KIND_END));
                        end
                    end
                    S_DPTR: begin
                        if (mem_done) begin
                            dptr_reg <= mem_rdata;
                            state_reg <= S_WORD;
                        end
                    end
                    S_WORD: begin
                        if (mem_done) begin
                            case (hold_reg.kind)
                                KIND_DATA: data_cnt_reg <= data_cnt_reg + 6'h01;
                                KIND_STATUS: stat_cnt_reg <= 1'b1;
                                default: cmd_cnt_reg <= 1'b1;
                            endcase
                            state_reg <= S_HOLD;
                        end
                    end
                    S_HOLD: begin
                        if (take_word) begin
                            msg_err_reg <= msg_err_reg | word_in.error;
                            hold_reg <= word_in;
                            state_reg <= (word_in.kind == KIND_END) ? S_CS : S_WORD;
                        end
                    end
                    S_CS: begin
                        if (mem_done) begin
                            state_reg <= S_TAIL;
                        end
                    end
                    S_TAIL: begin
                        if (mem_done) begin
                            state_reg <= S_IDLE;
                        end
                    end
                    default: state_reg <= S_IDLE;
                endcase
            end
        end
    end
endmodule

// file: test/bus_monitor_capture_irq_checker.sv
// Port checks and covers for the capture core
`timescale 1ns/100ps
module bus_monitor_capture_irq_checker
    import bus_monitor_pkg::*;
(
    input wire logic aclk, aresetn, ce, s_axi_awready, s_axi_bvalid, s_axi_bready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, word_ready,
    input wire mem_req_s mem_req,
    input wire logic mem_req_valid, mem_ack, std_irq_level_out, std_irq_pulse_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken during response");
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ce_freeze_a: assert property (!ce |-> !s_axi_awready && !s_axi_arready && !word_ready)
        else $error("ready while frozen");
    mem_hold_a: assert property (mem_req_valid && !mem_ack |=>
        mem_req_valid && $stable(mem_req))
        else $error("memory request changed before ack");
    word_block_a: assert property (mem_req_valid |-> !word_ready)
        else $error("bus word taken during memory access");
    level_pulse_a: assert property ($rose(std_irq_level_out) |->
        ##[0:1] std_irq_pulse_out)
        else $error("level without pulse");
    pulse_len_a: assert property ($rose(std_irq_pulse_out) |->
        std_irq_pulse_out[*8] ##5 std_irq_pulse_out ##1 !std_irq_pulse_out)
        else $error("pulse width wrong");
    cover property ($rose(std_irq_level_out));
    cover property (mem_req_valid && mem_ack);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind bus_monitor_capture_irq bus_monitor_capture_irq_checker chk_u (.*);

// file: test/mem_model.sv
// Shared memory answering the core's requests
`timescale 1ns/100ps
module mem_model
    import bus_monitor_pkg::*;
(
    input wire logic aclk,
    input wire mem_req_s mem_req,
    input wire logic mem_req_valid,
    output logic mem_ack = 1'b0,
    output logic [15:0] mem_rdata = 16'h0000
);
    logic [15:0] mem [0:255];
    int wait_cyc = 0;
    int cnt = 0;
    always @(posedge aclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req_valid && !mem_ack && cnt < wait_cyc) cnt <= cnt + 1;
        else if (mem_req_valid && !mem_ack) begin
            cnt <= 0;
            mem_ack <= 1'b1;
            if (mem_req.write) mem[mem_req.addr[7:0]] <= mem_req.wdata;
            else mem_rdata <= mem[mem_req.addr[7:0]];
        end
    end
endmodule

// file: test/bus_monitor_capture_irq_bench.sv
// Register, capture and interrupt tests for the core
`timescale 1ns/100ps
module bus_monitor_capture_irq_bench;
    import bus_monitor_pkg::*;
    logic aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, word_valid = 0, data_overrun = 0;
    logic mode_lock_pin = 0, subsystem_fail_pin = 0, self_test_fault_pin = 0;
    logic [6:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h3;
    bus_word_s word_in = '0;
    mem_req_s mem_req;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, word_ready;
    logic mem_req_valid, mem_ack, std_irq_level_out, std_irq_pulse_out, high_prio_irq_out;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] mem_rdata, q;
    logic pseen = 0, hseen = 0;
    int err_total = 0, compares = 0;
    bus_monitor_capture_irq dut_u (.*);
    mem_model mem_u (.*);
    initial forever #12.5 aclk = ~aclk;
    always @(posedge aclk) {pseen, hseen} <= {pseen | std_irq_pulse_out, hseen | high_prio_irq_out};
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [4:0] i, input logic [15:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {i, 2'b00, 16'h0000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(16'(s_axi_bresp), 16'(RESP_OKAY));
    endtask
    task rd(input logic [4:0] i);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        q = s_axi_rdata[15:0];
    endtask
    task wd(input logic [1:0] k, input logic [15:0] v);
        @(posedge aclk);
        word_in <= '{k, k == KIND_CMD, 1'b1, 1'b0, v};
        word_valid <= 1'b1;
        do @(posedge aclk); while (!word_ready);
        word_valid <= 1'b0;
    endtask
    task t_regs;
        rd(IDX_FILTER_LOW); chk(q, 16'h0000);
        wr(IDX_HP_ENABLE, 16'hFFFF); rd(IDX_HP_ENABLE); chk(q, HP_EN_MASK);
        wr(IDX_TERM_ADDR, 16'hFFFF); rd(IDX_TERM_ADDR); chk(q & 16'h0180, 16'h0000);
        rd(5'h1F); chk(16'(s_axi_rresp), 16'(RESP_SLVERR));
        $display("register test done");
    endtask
    task t_capture;
        for (int a = 8'h10; a < 8'h17; a++) mem_u.mem[a] = (a == 8'h13) ? 16'h0040 : 16'h0000;
        mem_u.mem[8'h16] = 16'h0020;
        mem_u.wait_cyc = 2;
        wr(IDX_MON_CTRL, 16'hC000); wr(IDX_CONTROL, 16'h0081);
        wr(IDX_CUR_BLOCK, 16'h0010); wr(IDX_STD_ENABLE, 16'h0001);
        rd(IDX_TERM_ADDR); chk(q & 16'h0180, 16'h0100);
        wd(KIND_CMD, 16'h0822); wd(KIND_DATA, 16'hAAAA); wd(KIND_DATA, 16'h5555);
        wd(KIND_STATUS, 16'h0800); wd(KIND_END, 16'h0000);
        @(posedge aclk);
        while (!word_ready) @(posedge aclk);
        chk(mem_u.mem[8'h11], 16'h0822); chk(mem_u.mem[8'h12], 16'h0000);
        chk(mem_u.mem[8'h40], 16'hAAAA); chk(mem_u.mem[8'h41], 16'h5555);
        chk(mem_u.mem[8'h14], 16'h0800);
        chk(mem_u.mem[8'h10] & 16'hF000, 16'hB000);
        rd(IDX_CUR_BLOCK); chk(q, 16'h0020);
        chk({13'h0, std_irq_level_out, pseen, hseen}, 16'h0006);
        wr(IDX_HP_STATUS, 16'h0001); chk(16'(std_irq_level_out), 16'h0000);
        $display("capture test done");
    endtask
    task t_reset;
        wr(IDX_FILTER_LOW, 16'h4546); wr(IDX_SOFT_RESET, 16'h0000);
        rd(IDX_FILTER_LOW); chk(q, 16'h4546);
        wr(IDX_SOFT_RESET, 16'h0001);
        repeat (SOFT_RESET_CYCLES + 2) @(posedge aclk);
        rd(IDX_FILTER_LOW); chk(q, 16'h0000);
        rd(IDX_HP_ENABLE); chk(q, HP_EN_MASK);
        mode_lock_pin <= 1'b1;
        wr(IDX_CONTROL, 16'h0180); wr(IDX_CONTROL, 16'h0000);
        rd(IDX_CONTROL); chk(q, 16'h0180);
        $display("programmed reset test done");
    endtask
    task t_overrun;
        @(posedge aclk);
        data_overrun <= 1'b1;
        @(posedge aclk);
        {ce, data_overrun} <= 2'b00;
        repeat (3) @(posedge aclk);
        ce <= 1'b1;
        rd(IDX_HP_STATUS); chk({q[8], 7'h0, high_prio_irq_out}, 9'h101);
        wr(IDX_HP_STATUS, 16'h0100); chk(16'(high_prio_irq_out), 16'h0000);
        $display("overrun test done");
    endtask
    task wrap_up;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_capture;
        t_reset;
        t_overrun;
        wrap_up;
    end
    initial begin
        repeat (30000) @(posedge aclk);
        err_total++;
        wrap_up;
    end
endmodule
